// ---- common/cal_result_regs.vh ----
// sfr addresses, reset values and field positions of the calibration and result bank
// assumes 8-bit sfr addresses and byte-wide data
`ifndef CAL_RESULT_REGS_VH
`define CAL_RESULT_REGS_VH

`define ADDR_GAIN_CAL_LOW 8'hAB
`define ADDR_GAIN_CAL_MID 8'hAC
`define ADDR_GAIN_CAL_HIGH 8'hAD
`define ADDR_OFFSET_CAL_LOW 8'hBA
`define ADDR_OFFSET_CAL_MID 8'hBB
`define ADDR_OFFSET_CAL_HIGH 8'hBC
`define ADDR_SINC_RESULT_LOW 8'hC3
`define ADDR_SINC_RESULT_MID 8'hC4
`define ADDR_SINC_RESULT_HIGH 8'hC5
`define ADDR_FAST_RESULT_LOW 8'hFC
`define ADDR_FAST_RESULT_MID 8'hFD
`define ADDR_FAST_RESULT_HIGH 8'hFE

`define RST_GAIN_CAL_HIGH 8'h80
`define RST_BYTE_ZERO 8'h00
`define RST_VALUE_ZERO 24'h000000

`define NUM_SLOTS 12
`define SLOT_W 4
`define SLOT_NONE 4'hF

`define FLD_HIGH_MSB 23
`define FLD_HIGH_LSB 16
`define FLD_MID_MSB 15
`define FLD_MID_LSB 8
`define FLD_LOW_MSB 7
`define FLD_LOW_LSB 0

`endif

// ---- logic/cal_byte_store.v ----
// byte store for the twelve sfr bytes, read data registered
// assumes one write port and one read port on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "cal_result_regs.vh"

module cal_byte_store
(
	// clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// write port
	input wire wr_en_i,
	input wire [3:0] wr_slot_i,
	input wire [7:0] wr_data_i,
	// read port
	input wire [3:0] rd_slot_i,
	output reg [7:0] rd_data_o,
	// flat view of all bytes
	output wire [95:0] all_bytes_o
);

	reg [7:0] mem [0:11];

	integer k;
	genvar g;

	// one process owns the whole array so every byte has a single driver
	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			// slot 2 is the gain high byte, the only nonzero reset
			for (k = 0; k < `NUM_SLOTS; k = k + 1)
				mem[k] <= (k == 2) ? `RST_GAIN_CAL_HIGH : `RST_BYTE_ZERO;
		end
		else if (wr_en_i && wr_slot_i < `NUM_SLOTS)
			mem[wr_slot_i] <= wr_data_i;
	end

	generate
		for (g = 0; g < `NUM_SLOTS; g = g + 1)
		begin : g_slot
			assign all_bytes_o[g*8+7:g*8] = mem[g];
		end
	endgenerate

	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rd_data_o <= `RST_BYTE_ZERO;
		else if (rd_slot_i < `NUM_SLOTS)
			rd_data_o <= mem[rd_slot_i];
		else
			rd_data_o <= `RST_BYTE_ZERO;
	end

endmodule // cal_byte_store
`default_nettype wire

// ---- logic/cal_result_bank.v ----
// calibration and conversion result sfr bank of a 24-bit delta-sigma converter
// assumes a byte-wide sfr bus from the core and a converter datapath beside it
//
// Operation
// - offset mid 0xBB, low 0xBA, read/write
// - offset high byte 0xBC, read/write, resets zero
// - offset mid and low reset to zero
// - gain bytes at 0xAD, 0xAC, 0xAB
// - gain high resets 0x80, others zero
// - sinc3 result bytes at 0xC5, 0xC4, 0xC3
// - sinc3 result middle byte resets zero
// - fast result high at 0xFE, resets zero
// - fast result mid 0xFD, low 0xFC
`timescale 1ns/10ps
`default_nettype none
`include "cal_result_regs.vh"

module cal_result_bank
(
	// clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// sfr bus
	input wire [7:0] sfr_addr_i,
	input wire sfr_wr_i,
	input wire sfr_rd_i,
	input wire [7:0] sfr_wdata_i,
	output reg [7:0] sfr_rdata_o,
	output reg sfr_hit_o,
	// converter datapath
	input wire sinc_done_i,
	input wire [23:0] sinc_raw_i,
	input wire fast_done_i,
	input wire [23:0] fast_raw_i,
	input wire cal_done_i,
	input wire cal_is_gain_i,
	input wire [23:0] cal_value_i,
	// calibration values to the filter
	output reg [23:0] offset_cal_value_o,
	output reg [23:0] gain_cal_value_o
);

	////////////////////////////////////////////////////////////////////////
	// address decode

	function [3:0] slot_of;
		input [7:0] addr;
		begin
			case (addr)
				`ADDR_GAIN_CAL_LOW: slot_of = 4'h0;
				`ADDR_GAIN_CAL_MID: slot_of = 4'h1;
				`ADDR_GAIN_CAL_HIGH: slot_of = 4'h2;
				`ADDR_OFFSET_CAL_LOW: slot_of = 4'h3;
				`ADDR_OFFSET_CAL_MID: slot_of = 4'h4;
				`ADDR_OFFSET_CAL_HIGH: slot_of = 4'h5;
				`ADDR_SINC_RESULT_LOW: slot_of = 4'h6;
				`ADDR_SINC_RESULT_MID: slot_of = 4'h7;
				`ADDR_SINC_RESULT_HIGH: slot_of = 4'h8;
				`ADDR_FAST_RESULT_LOW: slot_of = 4'h9;
				`ADDR_FAST_RESULT_MID: slot_of = 4'hA;
				`ADDR_FAST_RESULT_HIGH: slot_of = 4'hB;
				default: slot_of = `SLOT_NONE;
			endcase
		end
	endfunction

	// true for any of the twelve bank addresses
	function is_mapped;
		input [7:0] addr;
		begin
			is_mapped = (slot_of(addr) != `SLOT_NONE);
		end
	endfunction

	wire [3:0] bus_slot;
	wire bus_hit;
	assign bus_slot = slot_of(sfr_addr_i);
	assign bus_hit = is_mapped(sfr_addr_i);

	////////////////////////////////////////////////////////////////////////
	// hardware update sequencer: one byte per cycle, three cycles per value

	localparam ST_IDLE = 2'd0;
	localparam ST_B1 = 2'd1;
	localparam ST_B2 = 2'd2;

	// first store slot of each 24-bit value; the next two hold mid and high
	localparam [3:0] SLOT_GAIN_BASE = 4'h0;
	localparam [3:0] SLOT_OFFSET_BASE = 4'h3;
	localparam [3:0] SLOT_SINC_BASE = 4'h6;
	localparam [3:0] SLOT_FAST_BASE = 4'h9;

	// byte of a 24-bit value for update step 0, 1 or 2
	function [7:0] byte_pick;
		input [23:0] value;
		input [1:0] step;
		begin
			case (step)
				2'd0: byte_pick = value[`FLD_LOW_MSB:`FLD_LOW_LSB];
				2'd1: byte_pick = value[`FLD_MID_MSB:`FLD_MID_LSB];
				2'd2: byte_pick = value[`FLD_HIGH_MSB:`FLD_HIGH_LSB];
				default: byte_pick = `RST_BYTE_ZERO;
			endcase
		end
	endfunction

	reg [1:0] state;
	reg [1:0] next_state;
	reg [23:0] upd_value;
	reg [3:0] upd_base;
	reg [23:0] next_upd_value;
	reg [3:0] next_upd_base;
	reg hw_wr;
	reg [3:0] hw_slot;
	reg [7:0] hw_data;
	reg [23:0] corrected;

	wire [95:0] all_bytes;
	wire [23:0] gain_now;
	wire [23:0] offset_now;
	assign gain_now = all_bytes[23:0];
	assign offset_now = all_bytes[47:24];

	wire gain_shift;

	// gain below half scale but nonzero doubles the offset-corrected result
	assign gain_shift = (gain_now != `RST_VALUE_ZERO) && (gain_now[`FLD_HIGH_MSB] == 1'b0);

	always @*
	begin
		corrected = sinc_raw_i - offset_now;
		if (gain_shift)
			corrected = {corrected[22:0], 1'b0};
	end

	// done pulses that arrive while an update is in flight are dropped
	always @*
	begin
		next_state = state;
		next_upd_value = upd_value;
		next_upd_base = upd_base;
		hw_wr = 1'b0;
		hw_slot = `SLOT_NONE;
		hw_data = `RST_BYTE_ZERO;
		case (state)
			ST_IDLE:
			begin
				if (cal_done_i)
				begin
					next_upd_value = cal_value_i;
					next_upd_base = cal_is_gain_i ? SLOT_GAIN_BASE : SLOT_OFFSET_BASE;
					next_state = ST_B1;
				end
				else if (sinc_done_i)
				begin
					next_upd_value = corrected;
					next_upd_base = SLOT_SINC_BASE;
					next_state = ST_B1;
				end
				else if (fast_done_i)
				begin
					next_upd_value = fast_raw_i;
					next_upd_base = SLOT_FAST_BASE;
					next_state = ST_B1;
				end
				if (next_state == ST_B1)
				begin
					hw_wr = 1'b1;
					hw_slot = next_upd_base;
					hw_data = byte_pick(next_upd_value, 2'd0);
				end
			end
			// middle byte one cycle after the low byte
			ST_B1:
			begin
				hw_wr = 1'b1;
				hw_slot = upd_base + 4'h1;
				hw_data = byte_pick(upd_value, 2'd1);
				next_state = ST_B2;
			end
			// high byte last, then back to idle
			ST_B2:
			begin
				hw_wr = 1'b1;
				hw_slot = upd_base + 4'h2;
				hw_data = byte_pick(upd_value, 2'd2);
				next_state = ST_IDLE;
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= ST_IDLE;
			upd_value <= `RST_VALUE_ZERO;
			upd_base <= 4'h0;
		end
		else
		begin
			state <= next_state;
			upd_value <= next_upd_value;
			upd_base <= next_upd_base;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// byte store; hardware update wins over a bus write in the same cycle

	reg st_wr;
	reg [3:0] st_slot;
	reg [7:0] st_data;
	wire [7:0] rd_byte;

	// bus writes reach every mapped byte
	always @*
	begin
		st_wr = 1'b0;
		st_slot = `SLOT_NONE;
		st_data = `RST_BYTE_ZERO;
		// hardware update wins the store port
		if (hw_wr)
		begin
			st_wr = 1'b1;
			st_slot = hw_slot;
			st_data = hw_data;
		end
		else if (sfr_wr_i && bus_hit)
		begin
			st_wr = 1'b1;
			st_slot = bus_slot;
			st_data = sfr_wdata_i;
		end
	end

	// reset values held in the store
	cal_byte_store u_store
	(
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.wr_en_i(st_wr),
		.wr_slot_i(st_slot),
		.wr_data_i(st_data),
		.rd_slot_i(bus_slot),
		.rd_data_o(rd_byte),
		.all_bytes_o(all_bytes)
	);

	////////////////////////////////////////////////////////////////////////
	// read strobe alignment and registered outputs

	reg rd_q;
	reg hit_q;
	reg [7:0] next_rdata;
	reg next_hit;

	// read data only while the aligned strobe stands, zero otherwise
	always @*
	begin
		next_rdata = `RST_BYTE_ZERO;
		next_hit = 1'b0;
		if (rd_q)
		begin
			next_rdata = rd_byte;
			next_hit = hit_q;
		end
	end

	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_q <= 1'b0;
			hit_q <= 1'b0;
			sfr_rdata_o <= `RST_BYTE_ZERO;
			sfr_hit_o <= 1'b0;
			offset_cal_value_o <= `RST_VALUE_ZERO;
			// gain copy starts at half scale
			gain_cal_value_o <= {`RST_GAIN_CAL_HIGH, `RST_BYTE_ZERO, `RST_BYTE_ZERO};
		end
		else
		begin
			rd_q <= sfr_rd_i;
			hit_q <= sfr_rd_i & bus_hit;
			sfr_rdata_o <= next_rdata;
			sfr_hit_o <= next_hit;
			offset_cal_value_o <= offset_now;
			gain_cal_value_o <= gain_now;
		end
	end

endmodule // cal_result_bank
`default_nettype wire

// ---- sim/cal_result_bank_props.sv ----
// assertions on the bank ports
// assumes one clock domain, reset active high
`timescale 1ns/10ps
`default_nettype none
module cal_result_bank_props
(
	// clock, reset and bus
	input wire logic core_clk_i, rst_i, sfr_wr_i, sfr_rd_i, sfr_hit_o,
	input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
	// datapath
	input wire logic sinc_done_i, fast_done_i, cal_done_i, cal_is_gain_i,
	input wire logic [23:0] cal_value_i, offset_cal_value_o, gain_cal_value_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] hw;
	// no hardware update in flight
	wire q = !(hw || cal_done_i || sinc_done_i || fast_done_i);
	wire m = sfr_addr_i inside {8'hAB, 8'hAC, 8'hAD, 8'hBA, 8'hBB, 8'hBC, 8'hC3, 8'hC4, 8'hC5, 8'hFC, 8'hFD, 8'hFE};
	always @(posedge core_clk_i or posedge rst_i)
		if (rst_i)
			hw <= 2'h0;
		else
			hw <= {hw[0], cal_done_i | sinc_done_i | fast_done_i};
	a_read_hit:
		assert property (sfr_rd_i && m |-> ##2 sfr_hit_o) else $error("no hit");
	a_unmapped_read:
		assert property (sfr_rd_i && !m |-> ##2 !sfr_hit_o && sfr_rdata_o == 8'h00) else $error("unmapped hit");
	a_idle_quiet:
		assert property (!$past(sfr_rd_i, 2) |-> !sfr_hit_o && sfr_rdata_o == 8'h00) else $error("idle data");
	a_reset_cal:
		assert property ($past(rst_i) |-> offset_cal_value_o == 24'h0 && gain_cal_value_o == 24'h800000)
			else $error("cal reset");
	a_offset_write:
		assert property (sfr_wr_i && sfr_addr_i == 8'hBB && q |-> ##2 offset_cal_value_o[15:8] == $past(sfr_wdata_i, 2))
			else $error("offset write");
	a_gain_write:
		assert property (sfr_wr_i && sfr_addr_i == 8'hAD && q |-> ##2 gain_cal_value_o[23:16] == $past(sfr_wdata_i, 2))
			else $error("gain write");
	a_cal_offset:
		assert property (cal_done_i && !cal_is_gain_i && !hw |-> ##4 offset_cal_value_o == $past(cal_value_i, 4))
			else $error("offset cal");
	a_cal_gain:
		assert property (cal_done_i && cal_is_gain_i && !hw |-> ##4 gain_cal_value_o == $past(cal_value_i, 4))
			else $error("gain cal");
	c_cal: cover property (cal_done_i && cal_is_gain_i);
	c_sinc: cover property (sinc_done_i);
	c_miss: cover property (sfr_rd_i && !m);
endmodule // cal_result_bank_props
bind cal_result_bank cal_result_bank_props u_props (.core_clk_i, .rst_i, .sfr_wr_i, .sfr_rd_i, .sfr_hit_o,
	.sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .sinc_done_i, .fast_done_i, .cal_done_i, .cal_is_gain_i,
	.cal_value_i, .offset_cal_value_o, .gain_cal_value_o);
`default_nettype wire

// ---- sim/sfr_core_model.sv ----
// core side of the sfr bus
// assumes read data registered one edge after the edge that takes the strobe
`timescale 1ns/10ps
`default_nettype none
module sfr_core_model
(
	// clock and answer
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	input wire logic hit_i,
	// request
	output logic [7:0] addr_o = 8'h00,
	output logic [7:0] wdata_o = 8'h00,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0
);
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [8:0] r);
		@(posedge clk_i) #1;
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(posedge clk_i) #1;
		wr_o = 1'b0;
		rd_o = 1'b0;
		// released lines move away from the last value
		addr_o = ~a;
		wdata_o = ~d;
		// answer stands from the edge after the take edge until the next one
		@(posedge clk_i) #1;
		r = {hit_i, rdata_i};
	endtask
endmodule // sfr_core_model
`default_nettype wire

// ---- sim/tb_cal_result_bank.sv ----
// self-checking bench for the bank
// assumes the core model shares the clock
`timescale 1ns/10ps
`default_nettype none
module tb_cal_result_bank;
	logic core_clk_i = 1'b0, rst_i = 1'b1, sinc_done_i = 1'b0, fast_done_i = 1'b0;
	logic cal_done_i = 1'b0, cal_is_gain_i = 1'b0, sfr_wr_i, sfr_rd_i, sfr_hit_o;
	logic [23:0] sinc_raw_i = 24'h0, fast_raw_i = 24'h0, cal_value_i = 24'h0, offset_cal_value_o, gain_cal_value_o;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
	logic [8:0] r;
	logic [23:0] v, w, g;
	integer seed = 28, errors = 0, checks_done = 0, i;
	always #5 core_clk_i = ~core_clk_i;
	cal_result_bank DUT (.core_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
		.sfr_hit_o, .sinc_done_i, .sinc_raw_i, .fast_done_i, .fast_raw_i, .cal_done_i, .cal_is_gain_i,
		.cal_value_i, .offset_cal_value_o, .gain_cal_value_o);
	sfr_core_model core (.clk_i(core_clk_i), .rdata_i(sfr_rdata_o), .hit_i(sfr_hit_o), .addr_o(sfr_addr_i),
		.wdata_o(sfr_wdata_i), .wr_o(sfr_wr_i), .rd_o(sfr_rd_i));
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [23:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	function automatic logic mapd(input logic [7:0] a);
		return a inside {8'hAB, 8'hAC, 8'hAD, 8'hBA, 8'hBB, 8'hBC, 8'hC3, 8'hC4, 8'hC5, 8'hFC, 8'hFD, 8'hFE};
	endfunction
	function automatic logic [23:0] sx(input logic [23:0] a, o, gn);
		return (gn != 24'h0 && !gn[23]) ? (a - o) << 1 : a - o;
	endfunction
	task automatic rchk(input logic [7:0] a, e);
		core.acc(1'b0, a, 8'h00, r);
		chk({15'h0, r}, mapd(a) ? {16'h1, e} : 24'h0);
	endtask
	task automatic rd3(input logic [7:0] b, input logic [23:0] e);
		for (int k = 0; k < 3; k++)
			rchk(b + k[7:0], e[8 * k +: 8]);
	endtask
	// kind 0 sinc, 1 fast, 2 offset cal, 3 gain cal
	task automatic pulse(input integer kd, input logic [23:0] x);
		@(posedge core_clk_i) #1;
		{sinc_raw_i, fast_raw_i, cal_value_i} = {x, x, x};
		{sinc_done_i, fast_done_i, cal_done_i, cal_is_gain_i} = {kd == 0, kd == 1, kd > 1, kd == 3};
		@(posedge core_clk_i) #1;
		{sinc_done_i, fast_done_i, cal_done_i} = 3'h0;
		repeat (3) @(posedge core_clk_i);
		#1 {sinc_raw_i, fast_raw_i, cal_value_i} = {~x, ~x, ~x};
	endtask
	initial
	begin
		#400000 errors++;
		print_verdict;
	end
	initial
	begin
		repeat (20) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		for (i = 0; i < 256; i++)
			rchk(i[7:0], i == 8'hAD ? 8'h80 : 8'h00);
		$display("test reset done");
		for (i = 0; i < 256; i++)
		begin
			w = $random(seed);
			core.acc(1'b1, i[7:0], w[7:0], r);
			rchk(i[7:0], w[7:0]);
		end
		$display("test access done");
		v = $random(seed);
		pulse(1, v);
		rd3(8'hFC, v);
		w = $random(seed);
		pulse(2, w);
		g = $random(seed);
		pulse(3, g);
		chk(offset_cal_value_o, w);
		chk(gain_cal_value_o, g);
		rd3(8'hBA, w);
		rd3(8'hAB, g);
		$display("test cal done");
		for (i = 0; i < 3; i++)
		begin
			g = i == 0 ? 24'h0 : i == 1 ? 24'h400000 : 24'h800000;
			pulse(3, g);
			v = $random(seed);
			pulse(0, v);
			rd3(8'hC3, sx(v, w, g));
		end
		$display("test sinc done");
		// mid-run reset returns every byte to its reset value
		@(posedge core_clk_i) #1 rst_i = 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1 rst_i = 1'b0;
		chk(offset_cal_value_o, 24'h000000);
		chk(gain_cal_value_o, 24'h800000);
		rd3(8'hBA, 24'h000000);
		rd3(8'hAB, 24'h800000);
		rd3(8'hC3, 24'h000000);
		rd3(8'hFC, 24'h000000);
		$display("test rerun reset done");
		print_verdict;
	end
endmodule // tb_cal_result_bank
`default_nettype wire
